// *** cdcr_code_decode.sv ***
/*
  Decodes the exceedance-count and window-length codes into counts.
  Assumes codes come straight from the configuration register.
*/
`timescale 1ns/1ps
`default_nettype none
module cdcr_code_decode (
  input wire logic [2:0] count_code,
  input wire logic [2:0] window_code,
  output logic [7:0] count_target,
  output logic [11:0] window_len
);

  // ----------------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------------
  always_comb begin
    count_target = cdcr_pkg::DET_COUNT_TBL[count_code];
    window_len = cdcr_pkg::DET_WINDOW_TBL[window_code];
  end

endmodule : cdcr_code_decode
`default_nettype wire

// *** cdcr_detect.sv ***
/*
  Current-detect engine: counts over-limit conversions per window.
  Assumes conv_valid marks one conversion period on the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cdcr_detect #(
  parameter int NUM_CH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire cdcr_pkg::cdcr_det_s det_cfg,
  input wire logic [7:0] count_target,
  input wire logic [11:0] window_len,
  input wire logic conv_valid,
  input wire logic [NUM_CH*cdcr_pkg::DATA_W-1:0] conv_data,
  output logic detect_pulse,
  output logic [7:0] exceed_count
);

  localparam int DW = cdcr_pkg::DATA_W;

  logic [NUM_CH-1:0] over;
  logic [DW-1:0] limit_mag;
  logic hit;
  logic last;
  logic [7:0] cnt_d;
  logic [11:0] win_q;
  logic [7:0] cnt_q;
  logic fired_q;
  logic pulse_q;

  // ----------------------------------------------------------------------
  // Magnitude compare per channel
  // ----------------------------------------------------------------------
  assign limit_mag = det_cfg.detect_limit[DW-1] ?
                     (~det_cfg.detect_limit + 24'h00_0001) :
                     det_cfg.detect_limit;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [DW-1:0] s;
    logic [DW-1:0] mag;
    assign s = conv_data[ch*DW +: DW];
    assign mag = s[DW-1] ? (~s + 24'h00_0001) : s;
    assign over[ch] = mag > limit_mag;
  end

  assign hit = det_cfg.detect_all_channels ? &over : |over;
  assign last = win_q >= (window_len - 12'h001);
  assign cnt_d = (hit && cnt_q != 8'hff) ? cnt_q + 8'h01 : cnt_q;

  // ----------------------------------------------------------------------
  // Window and exceedance counters
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_q <= '0;
      cnt_q <= '0;
      fired_q <= 1'b0;
      pulse_q <= 1'b0;
    end else if (!det_cfg.detect_mode_on) begin
      win_q <= '0;
      cnt_q <= '0;
      fired_q <= 1'b0;
      pulse_q <= 1'b0;
    end else if (conv_valid) begin
      pulse_q <= !fired_q && (cnt_d >= count_target);
      if (last) begin
        win_q <= '0;
        cnt_q <= '0;
        fired_q <= 1'b0;
      end else begin
        win_q <= win_q + 12'h001;
        cnt_q <= cnt_d;
        fired_q <= fired_q || (cnt_d >= count_target);
      end
    end else begin
      pulse_q <= 1'b0;
    end
  end

  assign detect_pulse = pulse_q;
  assign exceed_count = cnt_q;

endmodule : cdcr_detect
`default_nettype wire

// *** cdcr_pkg.sv ***
/*
  Shared constants and types of the current-detect and channel-0
  calibration register bank: register indices, field positions, reset
  values, write masks, decode tables and the carrier structs.
  Assumes a single clock domain and an APB slave with 32-bit data.
*/
package cdcr_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int DATA_W = 24;
  localparam int IDX_W = 10;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_GLOBAL_CFG = 10'h006;
  localparam logic [IDX_W-1:0] IDX_LIMIT_HI = 10'h007;
  localparam logic [IDX_W-1:0] IDX_LIMIT_LO_DC = 10'h008;
  localparam logic [IDX_W-1:0] IDX_CH0_SETUP = 10'h009;
  localparam logic [IDX_W-1:0] IDX_CH0_OFS_HI = 10'h00a;
  localparam logic [IDX_W-1:0] IDX_CH0_OFS_LO = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_CH0_GAIN_HI = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_DETECT_STATUS = 10'h020;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_GLOBAL_CFG = 16'h0600;
  localparam logic [REG_W-1:0] RST_LIMIT_HI = 16'h0000;
  localparam logic [REG_W-1:0] RST_LIMIT_LO_DC = 16'h0000;
  localparam logic [REG_W-1:0] RST_CH0_SETUP = 16'h0000;
  localparam logic [REG_W-1:0] RST_CH0_OFS_HI = 16'h0000;
  localparam logic [REG_W-1:0] RST_CH0_OFS_LO = 16'h0000;
  localparam logic [REG_W-1:0] RST_CH0_GAIN_HI = 16'h8000;

  // ----------------------------------------------------------------------
  // Writable bits; all others read as zero
  // ----------------------------------------------------------------------
  localparam logic [REG_W-1:0] WMASK_FULL = 16'hffff;
  localparam logic [REG_W-1:0] WMASK_LIMIT_LO_DC = 16'hff0f;
  localparam logic [REG_W-1:0] WMASK_CH0_SETUP = 16'hffc7;
  localparam logic [REG_W-1:0] WMASK_UPPER_BYTE = 16'hff00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_MODE_ON_BIT = 0;
  localparam int CFG_WINDOW_LSB = 1;
  localparam int CFG_COUNT_LSB = 4;
  localparam int CFG_ALL_CH_BIT = 7;
  localparam int LIMIT_LO_LSB = 8;
  localparam int DC_SETTING_LSB = 0;
  localparam int CH0_PHASE_LSB = 6;
  localparam int CH0_DC_OFF_BIT = 2;
  localparam int CH0_INSEL_LSB = 0;
  localparam int OFS_LO_LSB = 8;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_COUNT_LSB = 8;
  localparam int GAIN_FRAC_BITS = 23;

  // ----------------------------------------------------------------------
  // Decode tables for exceedance count and window length
  // ----------------------------------------------------------------------
  localparam logic [7:0] DET_COUNT_TBL [8] = '{8'h01, 8'h02, 8'h04, 8'h08,
                                              8'h10, 8'h20, 8'h40, 8'h80};
  localparam logic [11:0] DET_WINDOW_TBL [8] = '{12'h080, 12'h100, 12'h200,
                                                 12'h300, 12'h500, 12'h700,
                                                 12'ha00, 12'he00};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    INSEL_NORMAL, INSEL_SHORTED, INSEL_POS_TEST, INSEL_NEG_TEST
  } cdcr_insel_e;

  typedef struct packed {
    logic [9:0] ch0_phase_shift;
    logic ch0_dc_removal_off;
    logic [3:0] dc_removal_setting;
    logic [3:0] ch0_dc_effective;
    cdcr_insel_e ch0_input_select;
    logic [DATA_W-1:0] ch0_offset;
    logic [DATA_W-1:0] ch0_gain;
  } cdcr_cal_s;

  typedef struct packed {
    logic detect_mode_on;
    logic detect_all_channels;
    logic [2:0] detect_count_select;
    logic [2:0] detect_window_length;
    logic [DATA_W-1:0] detect_limit;
  } cdcr_det_s;

endpackage : cdcr_pkg

// *** cdcr_regs.sv ***
/*
  APB register bank for current detect, DC removal and channel-0
  calibration, with the detect engine and a channel-0 correction stage.
  Assumes an APB master on pclk and conversion data on the same clock.
*/
// How it works
// - Count code selects 1 to 128 exceedances
// - Length code selects 128 to 3584 periods
// - Bit 0 enables current detect, resets off
// - Threshold 24 bits, split over two registers
// - Lower threshold bits 7:4 read zero
// - Bits 3:0 hold global DC removal setting
// - Channel 0 phase shift, 10-bit signed field
// - Channel 0 DC removal disable bit
// - Channel 0 input select, four choices
// - Offset upper register holds bits 23:8
// - Offset lower byte in 15:8, rest zero
// - Gain upper word resets to 8000h
// - Detect on any channel or all channels
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs #(
  parameter int NUM_CH = 8,
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_valid,
  input wire logic [NUM_CH*cdcr_pkg::DATA_W-1:0] conv_data,
  output cdcr_pkg::cdcr_cal_s cal_cfg,
  output logic detect_pulse,
  output logic detect_flag,
  output logic [cdcr_pkg::DATA_W-1:0] ch0_corr_data,
  output logic ch0_corr_valid
);

  localparam int RW = cdcr_pkg::REG_W;
  localparam int DW = cdcr_pkg::DATA_W;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [RW-1:0] global_configuration_q;
  logic [RW-1:0] detect_limit_high_word_q;
  logic [RW-1:0] detect_limit_low_and_dc_removal_q;
  logic [RW-1:0] channel0_setup_q;
  logic [RW-1:0] channel0_offset_high_word_q;
  logic [RW-1:0] channel0_offset_low_byte_q;
  logic [RW-1:0] channel0_gain_high_word_q;
  logic detect_flag_q;
  logic [31:0] prdata_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic setup;
  logic access;
  logic wr;
  logic [cdcr_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic mapped;
  logic [RW-1:0] lane_mask;
  logic [RW-1:0] rd_word;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign aligned = paddr[1:0] == 2'b00;
  assign idx = cdcr_pkg::IDX_W'(paddr[ADDR_W-1:2]);
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    case (idx)
      cdcr_pkg::IDX_GLOBAL_CFG,
      cdcr_pkg::IDX_LIMIT_HI,
      cdcr_pkg::IDX_LIMIT_LO_DC,
      cdcr_pkg::IDX_CH0_SETUP,
      cdcr_pkg::IDX_CH0_OFS_HI,
      cdcr_pkg::IDX_CH0_OFS_LO,
      cdcr_pkg::IDX_CH0_GAIN_HI,
      cdcr_pkg::IDX_DETECT_STATUS: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  assign wr = access && pwrite && mapped;
  assign pready = access;
  assign pslverr = access && !mapped;

  // Merge enabled byte lanes and writable bits into a register
  function automatic logic [RW-1:0] cdcr_merge(
    input logic [RW-1:0] old_val,
    input logic [RW-1:0] new_val,
    input logic [RW-1:0] lanes,
    input logic [RW-1:0] wmask
  );
    logic [RW-1:0] m;
    m = lanes & wmask;
    cdcr_merge = (old_val & ~m) | (new_val & m);
  endfunction : cdcr_merge

  // ----------------------------------------------------------------------
  // Global configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_configuration_q <= cdcr_pkg::RST_GLOBAL_CFG;
    end else if (wr && idx == cdcr_pkg::IDX_GLOBAL_CFG) begin
      global_configuration_q <= cdcr_merge(global_configuration_q,
        pwdata[RW-1:0], lane_mask, cdcr_pkg::WMASK_FULL);
    end
  end

  // ----------------------------------------------------------------------
  // Detect limit and DC removal
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_limit_high_word_q <= cdcr_pkg::RST_LIMIT_HI;
    end else if (wr && idx == cdcr_pkg::IDX_LIMIT_HI) begin
      detect_limit_high_word_q <= cdcr_merge(detect_limit_high_word_q,
        pwdata[RW-1:0], lane_mask, cdcr_pkg::WMASK_FULL);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_limit_low_and_dc_removal_q <= cdcr_pkg::RST_LIMIT_LO_DC;
    end else if (wr && idx == cdcr_pkg::IDX_LIMIT_LO_DC) begin
      detect_limit_low_and_dc_removal_q <= cdcr_merge(
        detect_limit_low_and_dc_removal_q, pwdata[RW-1:0], lane_mask,
        cdcr_pkg::WMASK_LIMIT_LO_DC);
    end
  end

  // ----------------------------------------------------------------------
  // Channel 0 setup
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel0_setup_q <= cdcr_pkg::RST_CH0_SETUP;
    end else if (wr && idx == cdcr_pkg::IDX_CH0_SETUP) begin
      channel0_setup_q <= cdcr_merge(channel0_setup_q, pwdata[RW-1:0],
        lane_mask, cdcr_pkg::WMASK_CH0_SETUP);
    end
  end

  // ----------------------------------------------------------------------
  // Channel 0 offset and gain
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel0_offset_high_word_q <= cdcr_pkg::RST_CH0_OFS_HI;
    end else if (wr && idx == cdcr_pkg::IDX_CH0_OFS_HI) begin
      channel0_offset_high_word_q <= cdcr_merge(
        channel0_offset_high_word_q, pwdata[RW-1:0], lane_mask,
        cdcr_pkg::WMASK_FULL);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel0_offset_low_byte_q <= cdcr_pkg::RST_CH0_OFS_LO;
    end else if (wr && idx == cdcr_pkg::IDX_CH0_OFS_LO) begin
      channel0_offset_low_byte_q <= cdcr_merge(
        channel0_offset_low_byte_q, pwdata[RW-1:0], lane_mask,
        cdcr_pkg::WMASK_UPPER_BYTE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel0_gain_high_word_q <= cdcr_pkg::RST_CH0_GAIN_HI;
    end else if (wr && idx == cdcr_pkg::IDX_CH0_GAIN_HI) begin
      channel0_gain_high_word_q <= cdcr_merge(channel0_gain_high_word_q,
        pwdata[RW-1:0], lane_mask, cdcr_pkg::WMASK_FULL);
    end
  end

  // ----------------------------------------------------------------------
  // Assembled datapath values
  // ----------------------------------------------------------------------
  cdcr_pkg::cdcr_det_s det_cfg;
  logic [7:0] count_target;
  logic [11:0] window_len;
  logic [7:0] exceed_count;
  logic det_pulse;

  always_comb begin
    det_cfg.detect_mode_on =
      global_configuration_q[cdcr_pkg::CFG_MODE_ON_BIT];
    det_cfg.detect_all_channels =
      global_configuration_q[cdcr_pkg::CFG_ALL_CH_BIT];
    det_cfg.detect_count_select =
      global_configuration_q[cdcr_pkg::CFG_COUNT_LSB +: 3];
    det_cfg.detect_window_length =
      global_configuration_q[cdcr_pkg::CFG_WINDOW_LSB +: 3];
    det_cfg.detect_limit = {detect_limit_high_word_q,
      detect_limit_low_and_dc_removal_q[cdcr_pkg::LIMIT_LO_LSB +: 8]};
  end

  always_comb begin
    cal_cfg.ch0_phase_shift =
      channel0_setup_q[cdcr_pkg::CH0_PHASE_LSB +: 10];
    cal_cfg.ch0_dc_removal_off =
      channel0_setup_q[cdcr_pkg::CH0_DC_OFF_BIT];
    cal_cfg.dc_removal_setting =
      detect_limit_low_and_dc_removal_q[cdcr_pkg::DC_SETTING_LSB +: 4];
    cal_cfg.ch0_dc_effective = cal_cfg.ch0_dc_removal_off ? 4'h0 :
      cal_cfg.dc_removal_setting;
    cal_cfg.ch0_input_select = cdcr_pkg::cdcr_insel_e'(
      channel0_setup_q[cdcr_pkg::CH0_INSEL_LSB +: 2]);
    cal_cfg.ch0_offset = {channel0_offset_high_word_q,
      channel0_offset_low_byte_q[cdcr_pkg::OFS_LO_LSB +: 8]};
    cal_cfg.ch0_gain = {channel0_gain_high_word_q, 8'h00};
  end

  // ----------------------------------------------------------------------
  // Detect engine
  // ----------------------------------------------------------------------
  cdcr_code_decode u_decode (
    .count_code(det_cfg.detect_count_select),
    .window_code(det_cfg.detect_window_length),
    .count_target(count_target),
    .window_len(window_len)
  );

  cdcr_detect #(
    .NUM_CH(NUM_CH)
  ) u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .det_cfg(det_cfg),
    .count_target(count_target),
    .window_len(window_len),
    .conv_valid(conv_valid),
    .conv_data(conv_data),
    .detect_pulse(det_pulse),
    .exceed_count(exceed_count)
  );

  assign detect_pulse = det_pulse;

  // Sticky flag, write one to clear; a new detection wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_flag_q <= 1'b0;
    end else if (det_pulse) begin
      detect_flag_q <= 1'b1;
    end else if (wr && idx == cdcr_pkg::IDX_DETECT_STATUS &&
                 pstrb[0] && pwdata[cdcr_pkg::STAT_FLAG_BIT]) begin
      detect_flag_q <= 1'b0;
    end
  end

  assign detect_flag = detect_flag_q;

  // ----------------------------------------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    case (idx)
      cdcr_pkg::IDX_GLOBAL_CFG: rd_word = global_configuration_q;
      cdcr_pkg::IDX_LIMIT_HI: rd_word = detect_limit_high_word_q;
      cdcr_pkg::IDX_LIMIT_LO_DC:
        rd_word = detect_limit_low_and_dc_removal_q;
      cdcr_pkg::IDX_CH0_SETUP: rd_word = channel0_setup_q;
      cdcr_pkg::IDX_CH0_OFS_HI: rd_word = channel0_offset_high_word_q;
      cdcr_pkg::IDX_CH0_OFS_LO:
        rd_word = channel0_offset_low_byte_q;
      cdcr_pkg::IDX_CH0_GAIN_HI: rd_word = channel0_gain_high_word_q;
      cdcr_pkg::IDX_DETECT_STATUS: begin
        rd_word[cdcr_pkg::STAT_FLAG_BIT] = detect_flag_q;
        rd_word[cdcr_pkg::STAT_ACTIVE_BIT] = det_cfg.detect_mode_on;
        rd_word[cdcr_pkg::STAT_COUNT_LSB +: 8] = exceed_count;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= (!pwrite && mapped) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;

  // ----------------------------------------------------------------------
  // Channel 0 offset and gain correction
  // ----------------------------------------------------------------------
  logic signed [DW:0] diff_d;
  logic signed [DW:0] diff_q;
  logic stage1_q;
  logic signed [2*DW+1:0] prod;
  logic signed [2*DW+1:0] scaled;
  logic [DW-1:0] sat;
  logic [DW-1:0] corr_q;
  logic corr_valid_q;

  assign diff_d = $signed({conv_data[DW-1], conv_data[DW-1:0]}) -
                  $signed({cal_cfg.ch0_offset[DW-1], cal_cfg.ch0_offset});
  assign prod = diff_q * $signed({1'b0, cal_cfg.ch0_gain});
  assign scaled = prod >>> cdcr_pkg::GAIN_FRAC_BITS;

  always_comb begin
    if (scaled > $signed({{(DW+3){1'b0}}, {(DW-1){1'b1}}})) begin
      sat = {1'b0, {(DW-1){1'b1}}};
    end else if (scaled < -$signed({{(DW+2){1'b0}}, 1'b1, {(DW-1){1'b0}}}))
    begin
      sat = {1'b1, {(DW-1){1'b0}}};
    end else begin
      sat = scaled[DW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_q <= '0;
      stage1_q <= 1'b0;
    end else begin
      stage1_q <= conv_valid;
      if (conv_valid) begin
        diff_q <= diff_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_q <= '0;
      corr_valid_q <= 1'b0;
    end else begin
      corr_valid_q <= stage1_q;
      if (stage1_q) begin
        corr_q <= sat;
      end
    end
  end

  assign ch0_corr_data = corr_q;
  assign ch0_corr_valid = corr_valid_q;

endmodule : cdcr_regs
`default_nettype wire

// *** cdcr_regs_chk.sv ***
/*
  Port checker for the current-detect and channel-0 calibration bank.
  Assumes one pclk domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire cdcr_pkg::cdcr_cal_s cal_cfg,
  input wire logic detect_pulse,
  input wire logic detect_flag
);
  logic [31:0] pw_q;
  // ----
  // Properties
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk) begin
    pw_q <= pwdata;
  end
  sequence wr_at(a);
    psel && penable && pwrite && pstrb[1:0] == 2'b11 && paddr == a;
  endsequence
  sequence rd_at(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  limit_resv_a: assert property (rd_at(12'h020) |->
    prdata[7:4] == 4'h0) else $error("limit reserved bits not zero");
  ofs_resv_a: assert property (rd_at(12'h02c) |->
    prdata[7:0] == 8'h00) else $error("offset reserved bits not zero");
  setup_wr_a: assert property (wr_at(12'h024) |=>
    cal_cfg.ch0_phase_shift == pw_q[15:6] &&
    cal_cfg.ch0_dc_removal_off == pw_q[2] &&
    cal_cfg.ch0_input_select == pw_q[1:0]) else $error("setup not applied");
  dc_follow_a: assert property (cal_cfg.ch0_dc_effective ==
    (cal_cfg.ch0_dc_removal_off ? 4'h0 : cal_cfg.dc_removal_setting))
    else $error("dc removal choice wrong");
  dc_wr_a: assert property (wr_at(12'h020) |=>
    cal_cfg.dc_removal_setting == pw_q[3:0]) else $error("dc setting");
  ofs_wr_a: assert property (wr_at(12'h028) |=>
    cal_cfg.ch0_offset[23:8] == pw_q[15:0]) else $error("offset upper");
  gain_wr_a: assert property (wr_at(12'h030) |=>
    cal_cfg.ch0_gain == {pw_q[15:0], 8'h00}) else $error("gain upper");
  flag_after_a: assert property (detect_pulse |=>
    detect_flag && !detect_pulse) else $error("detect pulse or flag");
endmodule : cdcr_regs_chk
bind cdcr_regs cdcr_regs_chk #(.ADDR_W(ADDR_W)) cdcr_regs_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .cal_cfg(cal_cfg),
  .detect_pulse(detect_pulse), .detect_flag(detect_flag));
`default_nettype wire

// *** cdcr_regs_test.sv ***
/*
  Self-checking bench for cdcr_regs over APB and conversion pulses.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs_test;
  localparam logic [191:0] HIT = {168'h0, 24'h00_0200};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, er;
  logic conv_valid, detect_pulse, detect_flag, corr_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [191:0] conv_data;
  logic [23:0] corr_data;
  cdcr_pkg::cdcr_cal_s cal_cfg;
  int err_total = 0;
  int checks_done = 0;
  int nv = 0;
  logic [11:0] adr [7] = '{12'h018, 12'h01c, 12'h020, 12'h024, 12'h028,
                           12'h02c, 12'h030};
  logic [15:0] rst_v [7] = '{16'h0600, 16'h0000, 16'h0000, 16'h0000,
                             16'h0000, 16'h0000, 16'h8000};
  logic [15:0] wmask [7] = '{16'hffff, 16'hffff, 16'hff0f, 16'hffc7,
                             16'hffff, 16'hff00, 16'hffff};
  always #20 pclk = ~pclk;
  always @(posedge pclk) nv <= nv + int'(corr_valid === 1'b1);
  cdcr_regs #(.NUM_CH(8), .ADDR_W(12)) cdcr_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_valid(conv_valid), .conv_data(conv_data), .cal_cfg(cal_cfg),
    .detect_pulse(detect_pulse), .detect_flag(detect_flag),
    .ch0_corr_data(corr_data), .ch0_corr_valid(corr_valid));
  // ----
  // Tasks
  // ----
  task automatic final_report();
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [15:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000, rd, er);
    chk("read", {16'h0000, e}, rd);
  endtask : rd_chk
  task automatic conv(input logic [191:0] d, input int n, output int h);
    h = 0;
    repeat (n) begin
      conv_data <= d;
      conv_valid <= 1'b1;
      @(posedge pclk);
      conv_valid <= 1'b0;
      #1 h += int'(detect_pulse === 1'b1);
      @(posedge pclk);
    end
  endtask : conv
  task automatic t_regs();
    chk("gain", 32'h0080_0000, {8'h00, cal_cfg.ch0_gain});
    for (int i = 0; i < 7; i++) begin
      rd_chk(adr[i], rst_v[i]);
      wr(adr[i], 16'hffff);
      rd_chk(adr[i], wmask[i]);
    end
    apb(1'b0, 12'h040, 16'h0000, rd, er);
    chk("slverr", 32'h0000_0001, {31'h0, er});
    chk("unmapped", 32'h0000_0000, rd);
  endtask : t_regs
  task automatic t_cal();
    int h;
    wr(12'h020, 16'h0005);
    for (int s = 0; s < 4; s++) begin
      wr(12'h024, {10'h201, 3'b000, s[0], s[1:0]});
      chk("insel", s, {30'h0, cal_cfg.ch0_input_select});
      chk("dc", s[0] ? 0 : 5, {28'h0, cal_cfg.ch0_dc_effective});
      chk("ph", 32'h0000_0201, {22'h0, cal_cfg.ch0_phase_shift});
    end
    wr(12'h028, 16'h1234);
    wr(12'h02c, 16'hab5a);
    chk("offset", 32'h0012_34ab, {8'h00, cal_cfg.ch0_offset});
    wr(12'h030, 16'h8000);
    conv({168'h0, 24'h22_34ab}, 1, h);
    rd_chk(12'h030, 16'h8000);
    chk("corr", 32'h0010_0000, {8'h00, corr_data});
    chk("corr_valid", 1, nv);
  endtask : t_cal
  task automatic t_det();
    int h;
    wr(12'h01c, 16'h0001);
    wr(12'h020, 16'h0000);
    for (int c = 0; c < 3; c++) begin
      wr(12'h018, 16'(c * 16 + 1));
      conv(HIT, (1 << c) - 1, h);
      chk("early", 0, h);
      conv(HIT, 1, h);
      chk("detect", 1, h);
      wr(12'h018, 16'h0000);
    end
    wr(12'h018, 16'h0011);
    conv(HIT, 1, h);
    conv('0, 127, h);
    conv(HIT, 1, h);
    chk("window", 0, h);
    conv(HIT, 1, h);
    chk("window", 1, h);
    wr(12'h018, 16'h0010);
    conv(HIT, 4, h);
    chk("off", 0, h);
    wr(12'h018, 16'h0081);
    conv(HIT, 2, h);
    chk("allch", 0, h);
    conv({8{24'h00_0200}}, 1, h);
    chk("allch", 1, h);
    rd_chk(12'h080, 16'h0103);
    chk("flag", 1, detect_flag);
    wr(12'h080, 16'h0001);
    chk("flag", 0, detect_flag);
    rd_chk(12'h080, 16'h0102);
  endtask : t_det
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    conv_valid = 1'b0;
    conv_data = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cal();
    t_det();
    final_report();
  end
endmodule : cdcr_regs_test
`default_nettype wire
